// ===== core/plc_core.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "plc_regs.vh"
// per-channel test pattern and loopback control
module plc_core #(
    parameter integer PERSIST_CYCLES = `PLC_PERSIST_MS * `PLC_CLK_KHZ,
    parameter integer CNT_W          = 28
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_r,
    input  wire        tx_bit,
    input  wire        tx_bit_valid,
    input  wire        rx_bit,
    input  wire        rx_bit_valid,
    input  wire        gen_tick,
    output reg         gen_bit_r,
    output reg         gen_valid_r,
    output reg         gen_to_rx_r,
    output reg         user_match_r,
    output reg         digital_loop_r,
    output reg         remote_loop_r,
    output reg         analog_loop_r
);
    localparam [3:0] ST_OFF    = 4'b0001;
    localparam [3:0] ST_PRBS   = 4'b0010;
    localparam [3:0] ST_USER   = 4'b0100;
    localparam [3:0] ST_INBAND = 4'b1000;

    reg  [7:0]  upat_lo_r;
    reg  [7:0]  upat_mid_r;
    reg  [7:0]  upat_hi_r;
    reg  [5:0]  code_len_r;
    reg  [7:0]  gen_code_r;
    reg  [7:0]  act_code_r;
    reg  [7:0]  deact_code_r;
    reg  [3:0]  loop_r;
    reg  [1:0]  gen_sel_r;
    reg         gen_dir_r;
    reg         det_dir_r;
    reg         auto_digital_r;
    reg         auto_remote_r;
    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [4:0]  idx_r;
    reg  [14:0] prbs_r;
    reg  [23:0] det_shift_r;
    reg  [4:0]  det_fill_r;
    reg  [7:0]  rdata_nxt;

    wire [23:0] user_pattern_bits;
    wire [1:0]  gen_code_length;
    wire [1:0]  activate_code_length;
    wire [1:0]  deactivate_code_length;
    wire        auto_loop_enable;
    wire        tx_act_match;
    wire        tx_act_persist;
    wire        tx_deact_match;
    wire        tx_deact_persist;
    wire        rx_act_match;
    wire        rx_act_persist;
    wire        rx_deact_match;
    wire        rx_deact_persist;
    wire        det_bit;
    wire        det_valid;
    wire [23:0] det_shift_nxt;
    wire [4:0]  gen_top;

    assign user_pattern_bits      = {upat_hi_r, upat_mid_r, upat_lo_r};
    assign gen_code_length        = code_len_r[`PLC_LEN_GEN_HI:`PLC_LEN_GEN_LO];
    assign activate_code_length   = code_len_r[`PLC_LEN_ACT_HI:`PLC_LEN_ACT_LO];
    assign deactivate_code_length = code_len_r[`PLC_LEN_DEACT_HI:`PLC_LEN_DEACT_LO];
    assign auto_loop_enable       = loop_r[`PLC_LOOP_AUTO_BIT];
    // last valid code bit index: length 5..8 gives index 4..7
    assign gen_top = {1'b0, `PLC_CODE_MIN_LEN - 4'h1} + {3'h0, gen_code_length};

    // register writes
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upat_lo_r    <= `PLC_RST_UPAT;
            upat_mid_r   <= `PLC_RST_UPAT;
            upat_hi_r    <= `PLC_RST_UPAT;
            code_len_r   <= `PLC_RST_CODE_LEN;
            gen_code_r   <= `PLC_RST_GEN_CODE;
            act_code_r   <= `PLC_RST_ACT_CODE;
            deact_code_r <= `PLC_RST_DEACT_CODE;
            loop_r       <= `PLC_RST_LOOP;
            gen_sel_r    <= `PLC_RST_GEN_SEL;
            gen_dir_r    <= 1'b0;
            det_dir_r    <= 1'b0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `PLC_OFF_GEN_CTRL:
                begin
                    gen_sel_r <= reg_wdata[`PLC_GEN_SEL_HI:`PLC_GEN_SEL_LO];
                    gen_dir_r <= reg_wdata[`PLC_GEN_DIR_BIT];
                end
                `PLC_OFF_DET_CTRL:   det_dir_r    <= reg_wdata[`PLC_DET_DIR_BIT];
                `PLC_OFF_UPAT_LO:    upat_lo_r    <= reg_wdata;
                `PLC_OFF_UPAT_MID:   upat_mid_r   <= reg_wdata;
                `PLC_OFF_UPAT_HI:    upat_hi_r    <= reg_wdata;
                `PLC_OFF_CODE_LEN:   code_len_r   <= reg_wdata[5:0];
                `PLC_OFF_GEN_CODE:   gen_code_r   <= reg_wdata;
                `PLC_OFF_ACT_CODE:   act_code_r   <= reg_wdata;
                `PLC_OFF_DEACT_CODE: deact_code_r <= reg_wdata;
                `PLC_OFF_LOOP:       loop_r       <= reg_wdata[3:0];
                default:             loop_r       <= loop_r;
            endcase
        end
    end

    // read mux, data valid in the cycle after the strobe only
    always @*
    begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `PLC_OFF_GEN_CTRL:   rdata_nxt = {2'h0, gen_sel_r, gen_dir_r, 3'h0};
            `PLC_OFF_DET_CTRL:   rdata_nxt = {4'h0, det_dir_r, 3'h0};
            `PLC_OFF_UPAT_LO:    rdata_nxt = upat_lo_r;
            `PLC_OFF_UPAT_MID:   rdata_nxt = upat_mid_r;
            `PLC_OFF_UPAT_HI:    rdata_nxt = upat_hi_r;
            `PLC_OFF_CODE_LEN:   rdata_nxt = {2'h0, code_len_r};
            `PLC_OFF_GEN_CODE:   rdata_nxt = gen_code_r;
            `PLC_OFF_ACT_CODE:   rdata_nxt = act_code_r;
            `PLC_OFF_DEACT_CODE: rdata_nxt = deact_code_r;
            `PLC_OFF_LOOP:       rdata_nxt = {4'h0, loop_r};
            `PLC_OFF_STATUS:     rdata_nxt = {user_match_r, auto_remote_r, auto_digital_r, rx_deact_match,
                                              rx_act_match, tx_deact_match, tx_act_match, gen_valid_r};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
            reg_rdata_r <= rdata_nxt;
        else
            reg_rdata_r <= 8'h00;
    end

    // generator mode selection
    always @*
    begin
        case (gen_sel_r)
            `PLC_SEL_OFF:    state_nxt = ST_OFF;
            `PLC_SEL_PRBS:   state_nxt = ST_PRBS;
            `PLC_SEL_USER:   state_nxt = ST_USER;
            `PLC_SEL_INBAND: state_nxt = ST_INBAND;
            default:         state_nxt = ST_OFF;
        endcase
    end

    // pattern generator; a mode change restarts the user and in-band sequences from their first bit, prbs_r keeps its state
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r     <= ST_OFF;
            idx_r       <= `PLC_PAT_TOP;
            prbs_r      <= `PLC_RST_PRBS;
            gen_bit_r   <= 1'b0;
            gen_valid_r <= 1'b0;
            gen_to_rx_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            gen_to_rx_r <= gen_dir_r;
            if (state_nxt != state_r)
            begin
                gen_valid_r <= 1'b0;
                idx_r       <= (state_nxt == ST_INBAND) ? gen_top : `PLC_PAT_TOP;
            end
            else if (gen_tick)
            begin
                case (state_r)
                    ST_OFF:
                    begin
                        gen_valid_r <= 1'b0;
                        gen_bit_r   <= 1'b0;
                    end
                    ST_PRBS:
                    begin
                        gen_valid_r <= 1'b1;
                        gen_bit_r   <= prbs_r[14];
                        prbs_r      <= {prbs_r[13:0], prbs_r[14] ^ prbs_r[13]};
                    end
                    ST_USER:
                    begin
                        gen_valid_r <= 1'b1;
                        gen_bit_r   <= user_pattern_bits[idx_r];
                        idx_r       <= (idx_r == 5'h00) ? `PLC_PAT_TOP : idx_r - 5'h01;
                    end
                    ST_INBAND:
                    begin
                        gen_valid_r <= 1'b1;
                        gen_bit_r   <= gen_code_r[idx_r[2:0]];
                        idx_r       <= (idx_r == 5'h00 || idx_r > gen_top) ? gen_top : idx_r - 5'h01;
                    end
                    default:
                    begin
                        gen_valid_r <= 1'b0;
                        gen_bit_r   <= 1'b0;
                    end
                endcase
            end
            else
                gen_valid_r <= 1'b0;
        end
    end

    // user pattern detector on the selected direction
    assign det_bit       = det_dir_r ? tx_bit : rx_bit;
    assign det_valid     = det_dir_r ? tx_bit_valid : rx_bit_valid;
    assign det_shift_nxt = {det_shift_r[22:0], det_bit};

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            det_shift_r  <= 24'h000000;
            det_fill_r   <= 5'h00;
            user_match_r <= 1'b0;
        end
        else if (det_valid)
        begin
            det_shift_r <= det_shift_nxt;
            if (det_fill_r != `PLC_PAT_LEN)
                det_fill_r <= det_fill_r + 5'h01;
            // oldest bit sits at 23, matching the first pattern bit
            user_match_r <= (det_shift_nxt == user_pattern_bits) && (det_fill_r >= `PLC_PAT_TOP);
        end
    end

    // in-band code detectors: activate and deactivate on each path
    plc_code_det #(.PERSIST_CYCLES(PERSIST_CYCLES), .CNT_W(CNT_W)) u_tx_act (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_in    (tx_bit),
        .bit_valid (tx_bit_valid),
        .code      (act_code_r),
        .code_len  (activate_code_length),
        .match_r   (tx_act_match),
        .persist_r (tx_act_persist)
    );

    plc_code_det #(.PERSIST_CYCLES(PERSIST_CYCLES), .CNT_W(CNT_W)) u_tx_deact (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_in    (tx_bit),
        .bit_valid (tx_bit_valid),
        .code      (deact_code_r),
        .code_len  (deactivate_code_length),
        .match_r   (tx_deact_match),
        .persist_r (tx_deact_persist)
    );

    plc_code_det #(.PERSIST_CYCLES(PERSIST_CYCLES), .CNT_W(CNT_W)) u_rx_act (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_in    (rx_bit),
        .bit_valid (rx_bit_valid),
        .code      (act_code_r),
        .code_len  (activate_code_length),
        .match_r   (rx_act_match),
        .persist_r (rx_act_persist)
    );

    plc_code_det #(.PERSIST_CYCLES(PERSIST_CYCLES), .CNT_W(CNT_W)) u_rx_deact (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bit_in    (rx_bit),
        .bit_valid (rx_bit_valid),
        .code      (deact_code_r),
        .code_len  (deactivate_code_length),
        .match_r   (rx_deact_match),
        .persist_r (rx_deact_persist)
    );

    // automatic loopback; deactivate wins if both fire together
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_digital_r <= 1'b0;
            auto_remote_r  <= 1'b0;
        end
        else if (!auto_loop_enable)
        begin
            auto_digital_r <= 1'b0;
            auto_remote_r  <= 1'b0;
        end
        else
        begin
            if (tx_deact_persist)
                auto_digital_r <= 1'b0;
            else if (tx_act_persist)
                auto_digital_r <= 1'b1;
            if (rx_deact_persist)
                auto_remote_r <= 1'b0;
            else if (rx_act_persist)
                auto_remote_r <= 1'b1;
        end
    end

    // loopback outputs
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            digital_loop_r <= 1'b0;
            remote_loop_r  <= 1'b0;
            analog_loop_r  <= 1'b0;
        end
        else
        begin
            digital_loop_r <= loop_r[`PLC_LOOP_DIG_BIT] | auto_digital_r;
            remote_loop_r  <= loop_r[`PLC_LOOP_REM_BIT] | auto_remote_r;
            analog_loop_r  <= loop_r[`PLC_LOOP_ANA_BIT];
        end
    end
endmodule

// ===== core/plc_regs.vh
// Functional notes
// - user pattern is one 24-bit sequence, bit 23 first, bit 0 last.
// - each user pattern byte register resets to 0x55.
// - generation length field 00..11 gives 5..8 valid low code bits, default 00.
// - activate length field 00..11 gives 5..8 valid low bits, default 00.
// - deactivate length field 00..11 gives 5..8 valid low bits, reset 01.
// - in-band generation sends valid code bits, bit 0 last, repeated until stopped.
// - activate detection compares incoming bits, code bit 0 matched last.
// - deactivate detection compares incoming bits, code bit 0 matched last.
// - auto loop enters digital or remote loop after activate code persists 5.1 s.
// - auto loop leaves digital or remote loop after deactivate code persists 5.1 s.
// - loopback register bit 2 enables digital loopback, default off.
// - loopback register bit 1 enables remote loopback, default off.
// - loopback register bit 0 enables analog loopback, default off.
// - generator select 00 off, 01 pseudo-random, 10 user pattern, 11 in-band code.
// - detect direction 0 selects receive path (default), 1 transmit path.
`ifndef PLC_REGS_VH
`define PLC_REGS_VH

`define PLC_ADDR_W          8
`define PLC_OFF_GEN_CTRL    8'h10
`define PLC_OFF_DET_CTRL    8'h11
`define PLC_OFF_UPAT_LO     8'h12
`define PLC_OFF_UPAT_MID    8'h13
`define PLC_OFF_UPAT_HI     8'h14
`define PLC_OFF_CODE_LEN    8'h15
`define PLC_OFF_GEN_CODE    8'h16
`define PLC_OFF_ACT_CODE    8'h17
`define PLC_OFF_DEACT_CODE  8'h18
`define PLC_OFF_LOOP        8'h19
`define PLC_OFF_STATUS      8'h20

`define PLC_RST_UPAT        8'h55
`define PLC_RST_CODE_LEN    6'h01
`define PLC_RST_GEN_CODE    8'h01
`define PLC_RST_ACT_CODE    8'h01
`define PLC_RST_DEACT_CODE  8'h09
`define PLC_RST_LOOP        4'h0
`define PLC_RST_GEN_SEL     2'h0
`define PLC_RST_PRBS        15'h7fff

// field positions
`define PLC_GEN_SEL_HI      5
`define PLC_GEN_SEL_LO      4
`define PLC_GEN_DIR_BIT     3
`define PLC_DET_DIR_BIT     3
`define PLC_LEN_GEN_HI      5
`define PLC_LEN_GEN_LO      4
`define PLC_LEN_ACT_HI      3
`define PLC_LEN_ACT_LO      2
`define PLC_LEN_DEACT_HI    1
`define PLC_LEN_DEACT_LO    0
`define PLC_LOOP_AUTO_BIT   3
`define PLC_LOOP_DIG_BIT    2
`define PLC_LOOP_REM_BIT    1
`define PLC_LOOP_ANA_BIT    0

// generator select codes
`define PLC_SEL_OFF         2'h0
`define PLC_SEL_PRBS        2'h1
`define PLC_SEL_USER        2'h2
`define PLC_SEL_INBAND      2'h3

// code lengths
`define PLC_CODE_MIN_LEN    4'h5
`define PLC_CODE_MAX_IDX    2'h3
`define PLC_PAT_LEN         5'h18
`define PLC_PAT_TOP         5'h17

// persistence time and clock rate
`define PLC_PERSIST_MS      5100
`define PLC_CLK_KHZ         50000

`endif

// ===== core/plc_code_det.v
`timescale 1ns/100ps
`include "plc_regs.vh"
// sliding in-band code matcher with persistence timer
module plc_code_det #(
    parameter integer PERSIST_CYCLES = `PLC_PERSIST_MS * `PLC_CLK_KHZ,
    parameter integer CNT_W          = 28
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire             bit_in,
    input  wire             bit_valid,
    input  wire [7:0]       code,
    input  wire [1:0]       code_len,
    output reg              match_r,
    output reg              persist_r
);
    reg  [7:0]       shift_r;
    reg  [3:0]       fill_r;
    reg  [CNT_W-1:0] cnt_r;
    wire [7:0]       mask;
    wire [3:0]       need;
    wire [7:0]       shift_nxt;
    wire             hit;

    assign mask      = 8'hff >> (`PLC_CODE_MAX_IDX - code_len);
    assign need      = `PLC_CODE_MIN_LEN + {2'h0, code_len};
    assign shift_nxt = {shift_r[6:0], bit_in};
    assign hit       = (((shift_nxt ^ code) & mask) == 8'h00) && ((fill_r + 4'h1) >= need);

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_r   <= 8'h00;
            fill_r    <= 4'h0;
            match_r   <= 1'b0;
            cnt_r     <= {CNT_W{1'b0}};
            persist_r <= 1'b0;
        end
        else
        begin
            persist_r <= 1'b0;
            if (bit_valid)
            begin
                shift_r <= shift_nxt;
                if (fill_r != 4'h8)
                    fill_r <= fill_r + 4'h1;
                match_r <= hit;
            end
            if (!match_r)
                cnt_r <= {CNT_W{1'b0}};
            else if (cnt_r != {CNT_W{1'b1}})
            begin
                cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                if (cnt_r == PERSIST_CYCLES[CNT_W-1:0])
                    persist_r <= 1'b1;
            end
        end
    end
endmodule

// ===== testbench/plc_core_properties.sv
`timescale 1ns/100ps
module plc_core_checker #(
    parameter integer PERSIST_CYCLES = 20
) (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_r,
    input wire       gen_tick,
    input wire       gen_valid_r,
    input wire       gen_to_rx_r,
    input wire       digital_loop_r,
    input wire       remote_loop_r,
    input wire       analog_loop_r
);
    reg [3:0] lp_r;
    reg [2:0] gc_r;
    integer   cyc_r;
    // shadow copies of loop and generator control
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lp_r <= 4'h0;
            gc_r <= 3'h0;
            cyc_r <= 0;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h19)
                lp_r <= reg_wdata[3:0];
            if (reg_wr && reg_addr == 8'h10)
                gc_r <= reg_wdata[5:3];
            if (cyc_r <= PERSIST_CYCLES)
                cyc_r <= cyc_r + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rd_idle; !reg_rd |=> reg_rdata_r == 8'h00; endproperty
    property p_loop_rd; reg_rd && reg_addr == 8'h19 |=> reg_rdata_r == {4'h0, lp_r}; endproperty
    property p_ana; lp_r[0] == $past(lp_r[0]) |-> analog_loop_r == lp_r[0]; endproperty
    property p_dig;
        !lp_r[3] && !$past(lp_r[3]) && !$past(lp_r[3], 2) && !$past(lp_r[3], 3) && lp_r[2] == $past(lp_r[2])
        |-> digital_loop_r == lp_r[2];
    endproperty
    property p_gen_idle; !gen_tick |=> !gen_valid_r; endproperty
    property p_gen_off; gen_tick && gc_r[2:1] == 2'h0 && $past(gc_r[2:1]) == 2'h0 |=> !gen_valid_r; endproperty
    property p_gen_dir; gc_r[0] == $past(gc_r[0]) |-> gen_to_rx_r == gc_r[0]; endproperty
    property p_dig_wait; $rose(digital_loop_r) && !$past(lp_r[2]) |-> cyc_r > PERSIST_CYCLES; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_loop_rd: assert property (p_loop_rd) else $error("loop register readback wrong");
    a_ana: assert property (p_ana) else $error("analog loop output wrong");
    a_dig: assert property (p_dig) else $error("digital loop output wrong");
    a_gen_idle: assert property (p_gen_idle) else $error("generator valid without tick");
    a_gen_off: assert property (p_gen_off) else $error("generator valid while off");
    a_gen_dir: assert property (p_gen_dir) else $error("generation direction wrong");
    a_dig_wait: assert property (p_dig_wait) else $error("auto loop entered too early");
    c_dig: cover property ($rose(digital_loop_r) && !lp_r[2]);
    c_rem: cover property ($rose(remote_loop_r) && !lp_r[1]);
    c_gen: cover property (gen_valid_r);
endmodule
bind plc_core plc_core_checker #(.PERSIST_CYCLES(PERSIST_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .gen_tick(gen_tick), .gen_valid_r(gen_valid_r),
    .gen_to_rx_r(gen_to_rx_r), .digital_loop_r(digital_loop_r), .remote_loop_r(remote_loop_r),
    .analog_loop_r(analog_loop_r));

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    reg        clk_sys, rst_n, reg_wr, reg_rd, tx_bit, tx_bit_valid, rx_bit, rx_bit_valid, gen_tick;
    reg [7:0]  reg_addr, reg_wdata, d, c;
    reg [23:0] pat;
    reg [14:0] q;
    wire [7:0] reg_rdata_r;
    wire       gen_bit_r, gen_valid_r, gen_to_rx_r, user_match_r, digital_loop_r, remote_loop_r, analog_loop_r;
    integer    mismatches, comparisons, i, p, j, k;
    plc_core #(.PERSIST_CYCLES(20), .CNT_W(28)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .gen_tick(gen_tick), .gen_bit_r(gen_bit_r),
        .gen_valid_r(gen_valid_r), .gen_to_rx_r(gen_to_rx_r), .user_match_r(user_match_r),
        .digital_loop_r(digital_loop_r), .remote_loop_r(remote_loop_r), .analog_loop_r(analog_loop_r));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    function [7:0] rv(input [7:0] a);
    begin
        case (a)
            8'h12, 8'h13, 8'h14: rv = 8'h55;
            8'h15, 8'h16, 8'h17: rv = 8'h01;
            8'h18: rv = 8'h09;
            default: rv = 8'h00;
        endcase
    end
    endfunction
    function [7:0] mk(input [7:0] a);
    begin
        case (a)
            8'h10: mk = 8'h38;
            8'h11: mk = 8'h08;
            8'h15: mk = 8'h3f;
            8'h19: mk = 8'h0f;
            8'h1a: mk = 8'h00;
            default: mk = 8'hff;
        endcase
    end
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    end
    endtask
    task rdchk(input [7:0] a, input [7:0] exp, input [7:0] m);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_r & m, exp);
    end
    endtask
    task settle;
    begin
        repeat (3) @(posedge clk_sys);
        #1;
    end
    endtask
    // n low bits of v, msb first, on tx when pt is 1 else rx
    task bits(input pt, input [23:0] v, input integer n);
    begin
        for (j = n - 1; j >= 0; j = j - 1)
        begin
            @(posedge clk_sys);
            tx_bit <= v[j];
            rx_bit <= v[j];
            tx_bit_valid <= pt;
            rx_bit_valid <= !pt;
        end
        @(posedge clk_sys);
        tx_bit_valid <= 1'b0;
        rx_bit_valid <= 1'b0;
    end
    endtask
    task ticks(input integer n, input [23:0] v, input integer len, input en);
    begin
        @(posedge clk_sys);
        gen_tick <= 1'b1;
        for (k = 0; k < n; k = k + 1)
        begin
            @(posedge clk_sys);
            if (k == n - 1)
                gen_tick <= 1'b0;
            #1;
            chk({7'h0, gen_valid_r}, {7'h0, en});
            if (len > 0)
                chk({7'h0, gen_bit_r}, {7'h0, v[len - 1 - k % len]});
            else if (en)
            begin
                chk({7'h0, gen_bit_r}, {7'h0, q[14]});
                q = {q[13:0], q[14] ^ q[13]};
            end
        end
    end
    endtask
    task finish_test;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #100000;
        mismatches = mismatches + 1;
        finish_test;
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, tx_bit, tx_bit_valid, rx_bit, rx_bit_valid, gen_tick} = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        mismatches = 0;
        comparisons = 0;
        d = $urandom(32'h8b4d5eb8);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 8'h10; i <= 8'h1a; i = i + 1)
            rdchk(i[7:0], rv(i[7:0]), 8'hff);
        for (i = 8'h10; i <= 8'h1a; i = i + 1)
        begin
            d = $urandom;
            wr(i[7:0], d);
            rdchk(i[7:0], d & mk(i[7:0]), 8'hff);
        end
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(8'h19, 8'h01 << i);
            settle;
            chk({5'h0, digital_loop_r, remote_loop_r, analog_loop_r}, 8'h01 << i);
        end
        wr(8'h19, 8'h00);
        $display("test registers done");
        pat = $urandom;
        wr(8'h12, pat[7:0]);
        wr(8'h13, pat[15:8]);
        wr(8'h14, pat[23:16]);
        wr(8'h10, 8'h20);
        ticks(48, pat, 24, 1'b1);
        for (p = 0; p < 2; p = p + 1)
        begin
            wr(8'h11, p << 3);
            bits(p, ~pat, 24);
            bits(!p, pat, 24);
            settle;
            chk({7'h0, user_match_r}, 8'h00);
            bits(p, pat, 24);
            settle;
            chk({7'h0, user_match_r}, 8'h01);
        end
        $display("test user pattern done");
        for (i = 0; i < 4; i = i + 1)
        begin
            c = $urandom;
            wr(8'h10, 8'h00);
            wr(8'h15, i << 4);
            wr(8'h16, c);
            wr(8'h10, 8'h30);
            ticks(2 * (i + 5), c, i + 5, 1'b1);
        end
        q = 15'h7fff;
        wr(8'h10, 8'h10);
        ticks(8, 24'h0, 0, 1'b1);
        wr(8'h10, 8'h00);
        ticks(4, 24'h0, 0, 1'b0);
        $display("test generation done");
        wr(8'h11, 8'h00);
        wr(8'h15, 8'h01);
        wr(8'h17, 8'h16);
        wr(8'h18, 8'h2c);
        for (p = 0; p < 2; p = p + 1)
        begin
            bits(p, 24'h00000d, 14);
            settle;
            rdchk(8'h20, 8'h00, p ? 8'h02 : 8'h10);
            bits(p, p ? 24'h16 : 24'h2c, 6);
            settle;
            rdchk(8'h20, p ? 8'h02 : 8'h10, p ? 8'h02 : 8'h10);
        end
        $display("test code detection done");
        wr(8'h15, 8'h00);
        wr(8'h17, 8'h1f);
        wr(8'h18, 8'h00);
        wr(8'h19, 8'h08);
        for (p = 1; p >= 0; p = p - 1)
        begin
            bits(p, 24'hffffff, 15);
            bits(p, 24'h0, 1);
            bits(p, 24'hffffff, 15);
            #1;
            chk({6'h0, digital_loop_r, remote_loop_r}, 8'h00);
            bits(p, 24'hffffff, 16);
            settle;
            chk({6'h0, digital_loop_r, remote_loop_r}, p ? 8'h02 : 8'h01);
            bits(p, 24'h0, 31);
            settle;
            chk({6'h0, digital_loop_r, remote_loop_r}, 8'h00);
        end
        $display("test auto loop done");
        finish_test;
    end
endmodule
